// file: rtl/ctm_cfg.svh
// Offsets, field positions and timing counts of the time monitor.
// Assumes a 100 MHz controller clock and a 32-bit AXI4-Lite register port.
`ifndef CTM_CFG_SVH
`define CTM_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define CTM_OFS_NOW      12'h000
`define CTM_OFS_PEAK     12'h004
`define CTM_OFS_STATUS   12'h008
`define CTM_OFS_CTRL     12'h00C
`define CTM_OFS_IRQ_STAT 12'h010
`define CTM_OFS_IRQ_MASK 12'h014

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CTM_CTRL_CLEAR_BIT  0
`define CTM_CTRL_SHORT_BIT  1
`define CTM_STAT_OVER_BIT   0
`define CTM_IRQ_OVER_BIT    0
`define CTM_IRQ_PERIOD_BIT  1

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CTM_CLK_MHZ         100
`define CTM_PERIOD_LONG_US  444
`define CTM_PERIOD_SHORT_US 222
`define CTM_PERIOD_LONG_CYC  (`CTM_PERIOD_LONG_US * `CTM_CLK_MHZ)
`define CTM_PERIOD_SHORT_CYC (`CTM_PERIOD_SHORT_US * `CTM_CLK_MHZ)
`define CTM_US_CYC           (`CTM_CLK_MHZ)

`endif

// file: rtl/ctm_pkg.sv
// Types for the cycle processing time monitor.
// Numbers live in the constants header.
package ctm_pkg;

    // ------------------------------------------------------------------------
    // Register bus response codes
    // ------------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        CTM_RESP_OKAY   = 2'b00,
        CTM_RESP_SLVERR = 2'b10
    } ctm_resp_t;

    // ------------------------------------------------------------------------
    // Measurement state
    // ------------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        CTM_ST_IDLE = 2'b00,
        CTM_ST_BUSY = 2'b01,
        CTM_ST_DONE = 2'b10
    } ctm_state_t;

endpackage

// file: rtl/ctm_period_timer.sv
// Period tick generator and microsecond prescaler for the time monitor.
// Assumes an active-low reset from the top module, asserted asynchronously and released on the clock.
`timescale 1ns/1ps
`include "ctm_cfg.svh"

module ctm_period_timer
    import ctm_pkg::*;
#(
    parameter int LONG_CYC  = `CTM_PERIOD_LONG_CYC,
    parameter int SHORT_CYC = `CTM_PERIOD_SHORT_CYC,
    parameter int US_CYC    = `CTM_US_CYC
)
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic short_i,
    output logic      period_tick_o,
    output logic      us_tick_o
);

    logic [31:0] per_cnt_reg;
    logic [15:0] us_cnt_reg;
    logic [31:0] per_last;

    // The period length follows the cycle selection at once, within the running period.
    assign per_last = short_i ? 32'(SHORT_CYC - 1) : 32'(LONG_CYC - 1);

    // --------------------------------------------------------------------
    // Period counter
    // --------------------------------------------------------------------
    // A shortened period ends at once if the counter is already past it.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            per_cnt_reg   <= 32'h0000_0000;
            period_tick_o <= 1'b0;
        end
        else if (per_cnt_reg >= per_last)
        begin
            per_cnt_reg   <= 32'h0000_0000;
            period_tick_o <= 1'b1;
        end
        else
        begin
            per_cnt_reg   <= per_cnt_reg + 32'h0000_0001;
            period_tick_o <= 1'b0;
        end
    end

    // --------------------------------------------------------------------
    // Microsecond prescaler
    // --------------------------------------------------------------------
    // Runs freely; periods are whole microseconds long.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            us_cnt_reg <= 16'h0000;
            us_tick_o  <= 1'b0;
        end
        else if (us_cnt_reg >= 16'(US_CYC - 1))
        begin
            us_cnt_reg <= 16'h0000;
            us_tick_o  <= 1'b1;
        end
        else
        begin
            us_cnt_reg <= us_cnt_reg + 16'h0001;
            us_tick_o  <= 1'b0;
        end
    end

endmodule

// file: rtl/ctm_top.sv
// Time monitor: busy time per period, its peak in microseconds, and an overrun flag.
// Assumes BUSY_I is on MCLK_I; registers are reached over AXI4-Lite.
//
// How it works
// - Latch busy time in microseconds each period.
// - Peak holds largest current value since clear.
// - Overrun flag sets when peak exceeds period.
// - While clear requested, peak follows current value.
// - Setting clear request drops the overrun flag.
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "ctm_cfg.svh"

module ctm_top
    import ctm_pkg::*;
#(
    parameter int TIME_W    = 16,
    parameter int LONG_CYC  = `CTM_PERIOD_LONG_CYC,
    parameter int SHORT_CYC = `CTM_PERIOD_SHORT_CYC
)
(
    input  wire logic        MCLK_I,
    input  wire logic        RESET_N_I,
    input  wire logic        BUSY_I,
    input  wire logic [11:0] S_AXI_AWADDR_I,
    input  wire logic        S_AXI_AWVALID_I,
    output logic             S_AXI_AWREADY_O,
    input  wire logic [31:0] S_AXI_WDATA_I,
    input  wire logic [3:0]  S_AXI_WSTRB_I,
    input  wire logic        S_AXI_WVALID_I,
    output logic             S_AXI_WREADY_O,
    output logic [1:0]       S_AXI_BRESP_O,
    output logic             S_AXI_BVALID_O,
    input  wire logic        S_AXI_BREADY_I,
    input  wire logic [11:0] S_AXI_ARADDR_I,
    input  wire logic        S_AXI_ARVALID_I,
    output logic             S_AXI_ARREADY_O,
    output logic [31:0]      S_AXI_RDATA_O,
    output logic [1:0]       S_AXI_RRESP_O,
    output logic             S_AXI_RVALID_O,
    input  wire logic        S_AXI_RREADY_I,
    output logic             IRQ_O
);

    // ------------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_n;

    // Assert asynchronously, release after two clean edges.
    always_ff @(posedge MCLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [TIME_W-1:0] cycle_time_now_reg;
    logic [TIME_W-1:0] cycle_time_peak_reg;
    logic              peak_overrun_flag_reg;
    logic              peak_clear_request_reg;
    logic              short_cycle_reg;
    logic [1:0]        irq_stat_reg;
    logic [1:0]        irq_mask_reg;
    logic [TIME_W-1:0] acc_reg;
    logic [TIME_W-1:0] acc_next;
    ctm_state_t        state_reg;
    logic              period_tick;
    logic              us_tick;
    logic [TIME_W-1:0] limit_us;
    logic [TIME_W-1:0] peak_next;
    logic              over_set;
    logic              clear_rise;
    logic              aw_held_reg;
    logic              w_held_reg;
    logic [11:0]       aw_addr_reg;
    logic [31:0]       w_data_reg;
    logic [3:0]        w_strb_reg;
    logic              wr_fire;
    logic              wr_hit;

    // Saturating increment keeps a runaway measurement pinned at full scale.
    function automatic logic [TIME_W-1:0] sat_inc(input logic [TIME_W-1:0] v);
        sat_inc = (&v) ? v : v + TIME_W'(1);
    endfunction

    // Offset compare for both bus paths.
    function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
        addr_is = ({a[11:2], 2'b00} == ofs);
    endfunction

    // ------------------------------------------------------------------------
    // Period and microsecond timing
    // ------------------------------------------------------------------------
    ctm_period_timer #(
        .LONG_CYC  (LONG_CYC),
        .SHORT_CYC (SHORT_CYC),
        .US_CYC    (`CTM_US_CYC)
    ) u_timer (
        .clk_i         (MCLK_I),
        .rst_n_i       (rst_n),
        .short_i       (short_cycle_reg),
        .period_tick_o (period_tick),
        .us_tick_o     (us_tick)
    );

    // The overrun limit in microseconds tracks the selected cycle.
    assign limit_us = short_cycle_reg ? TIME_W'(`CTM_PERIOD_SHORT_US) : TIME_W'(`CTM_PERIOD_LONG_US);

    // ------------------------------------------------------------------------
    // Busy interval measurement
    // ------------------------------------------------------------------------
    // Microseconds are counted while busy within the current period.
    always_comb
    begin
        acc_next = acc_reg;
        if (BUSY_I && us_tick)
        begin
            acc_next = sat_inc(acc_reg);
        end
    end

    // A microsecond that ends on the boundary counts in the new period.
    always_ff @(posedge MCLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_reg   <= '0;
            state_reg <= CTM_ST_IDLE;
        end
        else if (period_tick)
        begin
            acc_reg   <= TIME_W'(BUSY_I && us_tick);
            state_reg <= CTM_ST_IDLE;
        end
        else
        begin
            acc_reg <= acc_next;
            if (BUSY_I)
            begin
                state_reg <= CTM_ST_BUSY;
            end
            else if (state_reg == CTM_ST_BUSY)
            begin
                state_reg <= CTM_ST_DONE;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Current and peak time
    // ------------------------------------------------------------------------
    always_comb
    begin
        if (peak_clear_request_reg)
        begin
            peak_next = acc_reg;
        end
        else if (acc_reg > cycle_time_peak_reg)
        begin
            peak_next = acc_reg;
        end
        else
        begin
            peak_next = cycle_time_peak_reg;
        end
    end

    // Results update once per period; software cannot write them.
    always_ff @(posedge MCLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cycle_time_now_reg  <= '0;
            cycle_time_peak_reg <= '0;
        end
        else if (period_tick)
        begin
            cycle_time_now_reg  <= acc_reg;
            cycle_time_peak_reg <= peak_next;
        end
    end

    // ------------------------------------------------------------------------
    // Overrun flag
    // ------------------------------------------------------------------------
    assign over_set = (cycle_time_peak_reg > limit_us);

    // A held clear request wins over detection.
    always_ff @(posedge MCLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            peak_overrun_flag_reg <= 1'b0;
        end
        else if (over_set && !peak_clear_request_reg)
        begin
            peak_overrun_flag_reg <= 1'b1;
        end
        else if (peak_clear_request_reg)
        begin
            peak_overrun_flag_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Register write path
    // ------------------------------------------------------------------------
    assign wr_fire = aw_held_reg && w_held_reg && !S_AXI_BVALID_O;
    assign wr_hit  = addr_is(aw_addr_reg, `CTM_OFS_CTRL) || addr_is(aw_addr_reg, `CTM_OFS_IRQ_STAT)
                     || addr_is(aw_addr_reg, `CTM_OFS_IRQ_MASK);

    // Address and data are captured independently, in either order.
    always_ff @(posedge MCLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held_reg     <= 1'b0;
            w_held_reg      <= 1'b0;
            aw_addr_reg     <= 12'h000;
            w_data_reg      <= 32'h0000_0000;
            w_strb_reg      <= 4'h0;
            S_AXI_AWREADY_O <= 1'b0;
            S_AXI_WREADY_O  <= 1'b0;
            S_AXI_BVALID_O  <= 1'b0;
            S_AXI_BRESP_O   <= CTM_RESP_OKAY;
        end
        else
        begin
            S_AXI_AWREADY_O <= !aw_held_reg && !S_AXI_AWREADY_O && S_AXI_AWVALID_I;
            S_AXI_WREADY_O  <= !w_held_reg && !S_AXI_WREADY_O && S_AXI_WVALID_I;
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
            begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= S_AXI_AWADDR_I;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O)
            begin
                w_held_reg <= 1'b1;
                w_data_reg <= S_AXI_WDATA_I;
                w_strb_reg <= S_AXI_WSTRB_I;
            end
            if (wr_fire)
            begin
                S_AXI_BVALID_O <= 1'b1;
                S_AXI_BRESP_O  <= wr_hit ? CTM_RESP_OKAY : CTM_RESP_SLVERR;
            end
            else if (S_AXI_BVALID_O && S_AXI_BREADY_I)
            begin
                S_AXI_BVALID_O <= 1'b0;
                aw_held_reg    <= 1'b0;
                w_held_reg     <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------------
    // Only the control bits are writable; result registers ignore writes.
    always_ff @(posedge MCLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            peak_clear_request_reg <= 1'b0;
            short_cycle_reg        <= 1'b0;
        end
        else if (wr_fire && addr_is(aw_addr_reg, `CTM_OFS_CTRL) && w_strb_reg[0])
        begin
            peak_clear_request_reg <= w_data_reg[`CTM_CTRL_CLEAR_BIT];
            short_cycle_reg        <= w_data_reg[`CTM_CTRL_SHORT_BIT];
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------------
    assign clear_rise = over_set && !peak_overrun_flag_reg && !peak_clear_request_reg;

    // Events set sticky bits; a write of one clears, but a new event wins.
    always_ff @(posedge MCLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_stat_reg <= 2'b00;
            irq_mask_reg <= 2'b00;
        end
        else
        begin
            if (wr_fire && addr_is(aw_addr_reg, `CTM_OFS_IRQ_MASK) && w_strb_reg[0])
            begin
                irq_mask_reg <= w_data_reg[1:0];
            end
            if (wr_fire && addr_is(aw_addr_reg, `CTM_OFS_IRQ_STAT) && w_strb_reg[0])
            begin
                irq_stat_reg <= (irq_stat_reg & ~w_data_reg[1:0]) | {period_tick, clear_rise};
            end
            else
            begin
                irq_stat_reg <= irq_stat_reg | {period_tick, clear_rise};
            end
        end
    end

    // Registered, so the line comes from a flip-flop.
    always_ff @(posedge MCLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            IRQ_O <= 1'b0;
        end
        else
        begin
            IRQ_O <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // ------------------------------------------------------------------------
    // Register read path
    // ------------------------------------------------------------------------
    // One read at a time; no new address while an answer is pending.
    always_ff @(posedge MCLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O  <= 1'b0;
            S_AXI_RDATA_O   <= 32'h0000_0000;
            S_AXI_RRESP_O   <= CTM_RESP_OKAY;
        end
        else
        begin
            S_AXI_ARREADY_O <= S_AXI_ARVALID_I && !S_AXI_ARREADY_O && !S_AXI_RVALID_O;
            if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
            begin
                S_AXI_RVALID_O <= 1'b1;
                S_AXI_RRESP_O  <= CTM_RESP_OKAY;
                if (addr_is(S_AXI_ARADDR_I, `CTM_OFS_NOW))
                begin
                    S_AXI_RDATA_O <= 32'(cycle_time_now_reg);
                end
                else if (addr_is(S_AXI_ARADDR_I, `CTM_OFS_PEAK))
                begin
                    S_AXI_RDATA_O <= 32'(cycle_time_peak_reg);
                end
                else if (addr_is(S_AXI_ARADDR_I, `CTM_OFS_STATUS))
                begin
                    S_AXI_RDATA_O <= {28'h000_0000, state_reg, 1'b0, peak_overrun_flag_reg};
                end
                else if (addr_is(S_AXI_ARADDR_I, `CTM_OFS_CTRL))
                begin
                    S_AXI_RDATA_O <= {30'h0000_0000, short_cycle_reg, peak_clear_request_reg};
                end
                else if (addr_is(S_AXI_ARADDR_I, `CTM_OFS_IRQ_STAT))
                begin
                    S_AXI_RDATA_O <= {30'h0000_0000, irq_stat_reg};
                end
                else if (addr_is(S_AXI_ARADDR_I, `CTM_OFS_IRQ_MASK))
                begin
                    S_AXI_RDATA_O <= {30'h0000_0000, irq_mask_reg};
                end
                else
                begin
                    S_AXI_RDATA_O <= 32'h0000_0000;
                    S_AXI_RRESP_O <= CTM_RESP_SLVERR;
                end
            end
            else if (S_AXI_RVALID_O && S_AXI_RREADY_I)
            begin
                S_AXI_RVALID_O <= 1'b0;
            end
        end
    end

endmodule

// file: verification/ctm_top_sva.sv
// Port-level checks on the time monitor top.
// Assumes a bind from the bench; sees only the top's ports.
`timescale 1ns/1ps

module ctm_top_sva
    import ctm_pkg::*;
(
    input  wire logic        MCLK_I,
    input  wire logic        RESET_N_I,
    input  wire logic        S_AXI_AWREADY_O,
    input  wire logic [1:0]  S_AXI_BRESP_O,
    input  wire logic        S_AXI_BVALID_O,
    input  wire logic        S_AXI_BREADY_I,
    input  wire logic        S_AXI_ARVALID_I,
    input  wire logic        S_AXI_ARREADY_O,
    input  wire logic [31:0] S_AXI_RDATA_O,
    input  wire logic [1:0]  S_AXI_RRESP_O,
    input  wire logic        S_AXI_RVALID_O,
    input  wire logic        S_AXI_RREADY_I,
    input  wire logic        IRQ_O
);

    // ------------------------------------------------------------------------
    // One clock domain.
    // ------------------------------------------------------------------------
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!RESET_N_I);

    // Responses must stand until the master takes them; the write response must then drop.
    a_bvalid_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
        else $error("bresp not held");
    a_bvalid_drop: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O)
        else $error("bvalid stuck");
    a_rvalid_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=>
        S_AXI_RVALID_O && $stable(S_AXI_RDATA_O) && $stable(S_AXI_RRESP_O))
        else $error("rdata not held");
    a_awready_pulse: assert property (S_AXI_AWREADY_O |=> !S_AXI_AWREADY_O)
        else $error("awready too long");
    a_ar_answer: assert property (S_AXI_ARVALID_I && !S_AXI_ARREADY_O && !S_AXI_RVALID_O |-> ##[1:2] S_AXI_ARREADY_O)
        else $error("arready late");
    a_ar_to_rdata: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
        else $error("rvalid missing");
    // Registers are sixteen bits at most.
    a_rdata_width: assert property (S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:16] == 16'h0000)
        else $error("rdata upper bits set");
    a_slverr_zero: assert property (S_AXI_RVALID_O && S_AXI_RRESP_O == CTM_RESP_SLVERR |->
        S_AXI_RDATA_O == 32'h0000_0000)
        else $error("slverr data nonzero");
    // The internal reset outlasts the pin by two edges.
    a_reset_quiet: assert property ($rose(RESET_N_I) |-> !S_AXI_BVALID_O && !S_AXI_RVALID_O && !IRQ_O
        ##1 !S_AXI_BVALID_O && !S_AXI_RVALID_O && !IRQ_O)
        else $error("outputs active at release");

endmodule

// file: verification/tb.sv
// Self-checking bench for the time monitor: drives busy and the bus, models results.
// Assumes a shortened long period count and a short count one microsecond longer than its limit; the prescaler keeps its full count.
`timescale 1ns/1ps
`include "ctm_cfg.svh"

module tb;
    import ctm_pkg::*;

    localparam int LONG_CYC  = 2000;
    localparam int SHORT_CYC = 22300;
    localparam int LONG_US   = LONG_CYC / `CTM_US_CYC;
    localparam int SHORT_US  = SHORT_CYC / `CTM_US_CYC;

    logic        mclk, reset_n, busy, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [11:0] awaddr, araddr, a;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    integer      err_count, checked, cycles, seed, m_now, m_peak, m_flag, i;

    ctm_top #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC)) dut (
        .MCLK_I(mclk), .RESET_N_I(reset_n), .BUSY_I(busy),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
        .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
        .IRQ_O(irq));

    // ------------------------------------------------------------------------
    // Clock and hang guard.
    // ------------------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // About 80000 cycles are needed; more means a hang.
    always @(posedge mclk)
    begin
        cycles = cycles + 1;
        if (cycles == 98000)
        begin
            err_count = err_count + 1;
            end_sim();
        end
    end

    // ------------------------------------------------------------------------
    // Shared tasks.
    // ------------------------------------------------------------------------
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d.", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp)
        begin
            err_count = err_count + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Address and data go out together; each is released at its own handshake.
    task automatic wr(input logic [11:0] ad, input logic [31:0] v, input logic [1:0] er);
        @(posedge mclk);
        awaddr  <= ad;
        awvalid <= 1'b1;
        wdata   <= v;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        fork
            begin
                do @(posedge mclk); while (awready !== 1'b1);
                awvalid <= 1'b0;
            end
            begin
                do @(posedge mclk); while (wready !== 1'b1);
                wvalid <= 1'b0;
            end
        join
        while (bvalid !== 1'b1) @(posedge mclk);
        bready <= 1'b0;
        chk("bresp", {30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [11:0] ad, input logic [1:0] er);
        @(posedge mclk);
        araddr  <= ad;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge mclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge mclk); while (rvalid !== 1'b1);
        d = rdata;
        rready <= 1'b0;
        chk("rresp", {30'h0, rresp}, {30'h0, er});
    endtask

    task automatic rdc(input logic [11:0] ad, input logic [31:0] exp, input string what);
        rd(ad, CTM_RESP_OKAY);
        chk(what, d, exp);
    endtask

    // Clears the period event, then waits for the next boundary.
    task automatic tick();
        wr(`CTM_OFS_IRQ_STAT, 32'h0000_0002, CTM_RESP_OKAY);
        repeat (2) @(posedge mclk);
        do @(posedge mclk); while (irq !== 1'b1);
    endtask

    // Reference model of one full period with busy held steady throughout.
    task automatic period(input integer us, input integer clr, input integer lim);
        m_now  = us;
        m_peak = (clr != 0 || us > m_peak) ? us : m_peak;
        m_flag = (clr != 0) ? 0 : ((m_flag != 0 || m_peak > lim) ? 1 : 0);
    endtask

    task automatic results();
        rdc(`CTM_OFS_NOW, m_now, "now");
        rdc(`CTM_OFS_PEAK, m_peak, "peak");
        rd(`CTM_OFS_STATUS, CTM_RESP_OKAY);
        chk("overrun", {31'h0, d[`CTM_STAT_OVER_BIT]}, m_flag);
    endtask

    // ------------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------------
    initial
    begin
        {busy, awvalid, wvalid, bready, arvalid, rready, reset_n} = 7'h00;
        {awaddr, araddr, wdata} = 56'h0;
        wstrb = 4'hF;
        {err_count, checked, cycles, m_now, m_peak, m_flag} = 0;
        seed = 32'h7b04;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        // Reset values; refused writes leave results at zero.
        for (i = 0; i < 6; i = i + 1)
            rdc(i * 4, 32'h0000_0000, "reset value");
        for (i = 0; i < 3; i = i + 1)
        begin
            wr(i * 4, $random(seed), CTM_RESP_SLVERR);
            rdc(i * 4, 32'h0000_0000, "read only");
        end
        a = 12'h018 + {8'h0, 2'($random(seed)), 2'b00};
        wr(a, $random(seed), CTM_RESP_SLVERR);
        rd(a, CTM_RESP_SLVERR);
        wr(`CTM_OFS_IRQ_MASK, 32'h0000_0002, CTM_RESP_OKAY);
        rdc(`CTM_OFS_IRQ_MASK, 32'h0000_0002, "mask");
        // Long cycle: a busy period, then an idle one; peak keeps the maximum.
        busy <= 1'b1;
        tick();
        tick();
        period(LONG_US, 0, `CTM_PERIOD_LONG_US);
        results();
        busy <= 1'b0;
        tick();
        tick();
        period(0, 0, `CTM_PERIOD_LONG_US);
        results();
        // Initialise request: the peak follows the idle current value.
        wr(`CTM_OFS_CTRL, 32'h0000_0001, CTM_RESP_OKAY);
        tick();
        tick();
        period(0, 1, `CTM_PERIOD_LONG_US);
        results();
        wr(`CTM_OFS_CTRL, 32'h0000_0000, CTM_RESP_OKAY);
        // Short cycle stretched one microsecond past its limit, so the peak overruns.
        wr(`CTM_OFS_CTRL, 32'h0000_0002, CTM_RESP_OKAY);
        busy <= 1'b1;
        tick();
        tick();
        period(SHORT_US, 0, `CTM_PERIOD_SHORT_US);
        results();
        rdc(`CTM_OFS_IRQ_STAT, 32'h0000_0003, "irq status");
        // Unmask only the overrun event, then clear it and see the line fall.
        wr(`CTM_OFS_IRQ_MASK, 32'h0000_0001, CTM_RESP_OKAY);
        wr(`CTM_OFS_IRQ_STAT, 32'h0000_0002, CTM_RESP_OKAY);
        repeat (2) @(posedge mclk);
        chk("irq pending", {31'h0, irq}, 32'h0000_0001);
        wr(`CTM_OFS_IRQ_STAT, 32'h0000_0001, CTM_RESP_OKAY);
        repeat (2) @(posedge mclk);
        chk("irq cleared", {31'h0, irq}, 32'h0000_0000);
        wr(`CTM_OFS_IRQ_MASK, 32'h0000_0002, CTM_RESP_OKAY);
        // Initialise while still overrunning: the flag drops at once and stays down.
        wr(`CTM_OFS_CTRL, 32'h0000_0003, CTM_RESP_OKAY);
        m_flag = 0;
        rd(`CTM_OFS_STATUS, CTM_RESP_OKAY);
        chk("overrun cleared", {31'h0, d[`CTM_STAT_OVER_BIT]}, m_flag);
        tick();
        period(SHORT_US, 1, `CTM_PERIOD_SHORT_US);
        results();
        end_sim();
    end

endmodule

bind ctm_top ctm_top_sva u_sva (
    .MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
    .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
    .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RDATA_O(S_AXI_RDATA_O),
    .S_AXI_RRESP_O(S_AXI_RRESP_O), .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
    .IRQ_O(IRQ_O));
